// >>> design/channel_pair_combine_control.sv
/*
  control of the first channel pair of the flexible timer unit: function
  select register, output combining and inversion, deadtime, fault gating,
  synchronised value update and dual edge capture, behind classic wishbone.
  assumes pwm levels, counter and sync pulse come from logic on clk_i;
  capture and fault pins are asynchronous.
*/
// Local design decisions: the register offsets and the Wishbone interface to the registers.
// Contract
// - top bit reserved, reads zero, ignores writes
// - fault enable bit gates pair fault control
// - guarded fields written only with guard off
// - sync bit defers value updates to sync
// - deadtime bit inserts deadtime on pair outputs
// - arm starts capture, needs enable and dual-edge
// - one-shot mode clears arm after odd capture
// - dual-edge bit reinterprets mode and edge selects
// - combined odd output equals or inverts even
// - join bit combines pair, else independent
`timescale 1ns/1ps
`default_nettype none
module channel_pair_combine_control #(
  parameter int VAL_W = pair_ctl_pkg::VAL_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pair_ctl_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timer side, same clock
  input wire logic pwm_even_i,
  input wire logic pwm_odd_i,
  input wire logic [VAL_W-1:0] counter_i,
  input wire logic value_sync_i,
  // pins, asynchronous
  input wire logic cap_even_pin_i,
  input wire logic cap_odd_pin_i,
  input wire logic fault_pin_i,
  // pair outputs
  output logic pwm_ch0_o,
  output logic pwm_ch1_o,
  output logic [VAL_W-1:0] chan_value_even_o,
  output logic [VAL_W-1:0] chan_value_odd_o,
  output logic dual_edge_active_o,
  output logic pair_fault_ctl_on_o
);
  typedef struct packed {
    logic [7:0] func; // channel_pair_function_select
    logic write_guard_off; // guarded fields writable
    logic timer_extended_features_on; // module enable
    logic chan_mode_sel_a; // 1 continuous, 0 one-shot
    logic [1:0] edge_even; // even channel edge select
    logic [1:0] edge_odd; // odd channel edge select
    logic [pair_ctl_pkg::DT_W-1:0] dt_count; // deadtime cycles
    logic [VAL_W-1:0] val_even_buf; // written values
    logic [VAL_W-1:0] val_odd_buf;
    logic [VAL_W-1:0] val_even; // values in use
    logic [VAL_W-1:0] val_odd;
    logic [VAL_W-1:0] capt_even; // captured counter values
    logic [VAL_W-1:0] capt_odd;
    logic done; // sticky pair captured
    pair_ctl_pkg::cap_state_t state; // capture sequencer
    logic [2:0] even_sync; // [0] first stage, [2] previous
    logic [2:0] odd_sync;
    logic [1:0] fault_sync;
    logic ack; // bus answer
    logic [31:0] dat; // read data
    logic ch0; // gated outputs
    logic ch1;
    logic dual_active;
  } state_t;

  state_t s_reg;
  state_t s_next;

  deadtime_if dt ();

  // merge write data into a word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // true when the selected edge kind occurred
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic now, input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    case (sel)
      pair_ctl_pkg::EDGE_RISE: edge_hit = rise;
      pair_ctl_pkg::EDGE_FALL: edge_hit = fall;
      pair_ctl_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // deadtime inserter
  deadtime_insert u_deadtime (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dt(dt.ins)
  );

  logic even_src; // even level before deadtime
  logic odd_src; // odd level before deadtime

  // pair output routing
  always_comb begin
    even_src = pwm_even_i;
    if (s_reg.func[pair_ctl_pkg::JOIN_BIT]) begin
      // one pwm function drives both pins
      odd_src = s_reg.func[pair_ctl_pkg::INVERT_BIT] ?
                ~pwm_even_i : pwm_even_i;
    end else begin
      odd_src = pwm_odd_i;
    end
  end

  assign dt.en = s_reg.func[pair_ctl_pkg::DEADTIME_BIT];
  assign dt.count = s_reg.dt_count;
  assign dt.want = {odd_src, even_src};

  // outputs straight from the state register
  assign wb_dat_o = s_reg.dat;
  assign wb_ack_o = s_reg.ack;
  assign pwm_ch0_o = s_reg.ch0;
  assign pwm_ch1_o = s_reg.ch1;
  assign chan_value_even_o = s_reg.val_even;
  assign chan_value_odd_o = s_reg.val_odd;
  assign dual_edge_active_o = s_reg.dual_active;
  assign pair_fault_ctl_on_o = s_reg.func[pair_ctl_pkg::FAULT_BIT];

  logic do_write; // write takes effect at the acked edge
  logic [31:0] wv; // merged write word
  logic [31:0] cfg_word; // config register image
  logic [31:0] status_word; // status register image
  logic dual_on; // dual edge mode in force
  logic armed; // captures in force
  logic fault_active; // fault forcing outputs low
  logic even_ev; // even channel edge seen
  logic odd_ev; // odd channel edge seen
  logic [7:0] fsel; // function select after write

  // next state
  always_comb begin
    s_next = s_reg;
    wv = '0;
    fsel = s_reg.func;
    cfg_word = '0;
    status_word = '0;
    do_write = wb_cyc_i & wb_stb_i & wb_we_i & s_reg.ack;
    // pin synchronisers, first stage read only by the second
    s_next.even_sync = {s_reg.even_sync[1:0], cap_even_pin_i};
    s_next.odd_sync = {s_reg.odd_sync[1:0], cap_odd_pin_i};
    s_next.fault_sync = {s_reg.fault_sync[0], fault_pin_i};
    even_ev = edge_hit(s_reg.edge_even, s_reg.even_sync[1],
                       s_reg.even_sync[2]);
    odd_ev = edge_hit(s_reg.edge_odd, s_reg.odd_sync[1],
                      s_reg.odd_sync[2]);
    // dual edge mode only with module enable
    dual_on = s_reg.func[pair_ctl_pkg::DUAL_EDGE_BIT] &
              s_reg.timer_extended_features_on;
    armed = dual_on & s_reg.func[pair_ctl_pkg::ARM_BIT];
    fault_active = s_reg.func[pair_ctl_pkg::FAULT_BIT] &
                   s_reg.fault_sync[1];
    s_next.dual_active = dual_on;

    // capture sequencer
    case (s_reg.state)
      pair_ctl_pkg::CAP_IDLE: begin
        if (armed) begin
          s_next.state = pair_ctl_pkg::CAP_WAIT_EVEN;
        end
      end
      pair_ctl_pkg::CAP_WAIT_EVEN: begin
        if (!armed) begin
          s_next.state = pair_ctl_pkg::CAP_IDLE;
        end else if (even_ev) begin
          // even edge opens the measurement
          s_next.capt_even = counter_i;
          s_next.state = pair_ctl_pkg::CAP_WAIT_ODD;
        end
      end
      pair_ctl_pkg::CAP_WAIT_ODD: begin
        if (!armed) begin
          s_next.state = pair_ctl_pkg::CAP_IDLE;
        end else if (odd_ev) begin
          s_next.capt_odd = counter_i;
          s_next.done = 1'b1;
          if (s_reg.chan_mode_sel_a) begin
            // continuous: wait for the next even edge
            s_next.state = pair_ctl_pkg::CAP_WAIT_EVEN;
          end else begin
            // one-shot: disarm after the odd capture
            s_next.func[pair_ctl_pkg::ARM_BIT] = 1'b0;
            s_next.state = pair_ctl_pkg::CAP_IDLE;
          end
        end
      end
      default: begin
        s_next.state = pair_ctl_pkg::CAP_IDLE;
      end
    endcase

    // synchronised value update on the sync pulse
    if (s_reg.func[pair_ctl_pkg::SYNC_BIT] && value_sync_i) begin
      s_next.val_even = s_reg.val_even_buf;
      s_next.val_odd = s_reg.val_odd_buf;
    end

    // register images
    cfg_word[pair_ctl_pkg::CFG_GUARD_OFF_BIT] = s_reg.write_guard_off;
    cfg_word[pair_ctl_pkg::CFG_EXT_ON_BIT] =
      s_reg.timer_extended_features_on;
    cfg_word[pair_ctl_pkg::CFG_MODE_A_BIT] = s_reg.chan_mode_sel_a;
    cfg_word[pair_ctl_pkg::CFG_EDGE_EVEN_LSB +: 2] = s_reg.edge_even;
    cfg_word[pair_ctl_pkg::CFG_EDGE_ODD_LSB +: 2] = s_reg.edge_odd;
    cfg_word[pair_ctl_pkg::CFG_DT_LSB +: pair_ctl_pkg::DT_W] =
      s_reg.dt_count;
    status_word[pair_ctl_pkg::ST_DONE_BIT] = s_reg.done;
    status_word[pair_ctl_pkg::ST_ACTIVE_BIT] = armed;
    status_word[pair_ctl_pkg::ST_STATE_LSB +: 3] = s_reg.state;
    status_word[pair_ctl_pkg::ST_FAULT_BIT] = fault_active;

    // bus writes, after hardware so software arming wins
    if (do_write) begin
      case (wb_adr_i)
        pair_ctl_pkg::FUNC_OFS: begin
          wv = merge({24'h000000, s_reg.func}, wb_dat_i, wb_sel_i);
          // guarded fields keep their value while the guard is on
          fsel = s_reg.write_guard_off ? wv[7:0] : s_reg.func;
          s_next.func = (fsel & pair_ctl_pkg::FUNC_GUARDED) |
                        (wv[7:0] & pair_ctl_pkg::FUNC_FREE);
          // reserved top bit lies in neither mask
        end
        pair_ctl_pkg::CFG_OFS: begin
          wv = merge(cfg_word, wb_dat_i, wb_sel_i);
          s_next.write_guard_off = wv[pair_ctl_pkg::CFG_GUARD_OFF_BIT];
          s_next.timer_extended_features_on =
            wv[pair_ctl_pkg::CFG_EXT_ON_BIT];
          s_next.chan_mode_sel_a = wv[pair_ctl_pkg::CFG_MODE_A_BIT];
          s_next.edge_even = wv[pair_ctl_pkg::CFG_EDGE_EVEN_LSB +: 2];
          s_next.edge_odd = wv[pair_ctl_pkg::CFG_EDGE_ODD_LSB +: 2];
          if (s_reg.write_guard_off) begin
            s_next.dt_count =
              wv[pair_ctl_pkg::CFG_DT_LSB +: pair_ctl_pkg::DT_W];
          end
        end
        pair_ctl_pkg::VAL_EVEN_OFS: begin
          wv = merge({{(32-VAL_W){1'b0}}, s_reg.val_even_buf},
                     wb_dat_i, wb_sel_i);
          s_next.val_even_buf = wv[VAL_W-1:0];
          if (!s_reg.func[pair_ctl_pkg::SYNC_BIT]) begin
            s_next.val_even = wv[VAL_W-1:0];
          end
        end
        pair_ctl_pkg::VAL_ODD_OFS: begin
          wv = merge({{(32-VAL_W){1'b0}}, s_reg.val_odd_buf},
                     wb_dat_i, wb_sel_i);
          s_next.val_odd_buf = wv[VAL_W-1:0];
          if (!s_reg.func[pair_ctl_pkg::SYNC_BIT]) begin
            s_next.val_odd = wv[VAL_W-1:0];
          end
        end
        pair_ctl_pkg::STATUS_OFS: begin
          // write one clears, a new capture in this cycle wins unless done was already set
          if (wb_sel_i[0] && wb_dat_i[pair_ctl_pkg::ST_DONE_BIT] &&
              !(s_next.done && !s_reg.done)) begin
            s_next.done = 1'b0;
          end
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end

    // bus answer one cycle after the request
    s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
      case (wb_adr_i)
        pair_ctl_pkg::FUNC_OFS: s_next.dat =
          {24'h000000, 1'b0, s_reg.func[6:0]};
        pair_ctl_pkg::CFG_OFS: s_next.dat = cfg_word;
        pair_ctl_pkg::VAL_EVEN_OFS: s_next.dat =
          {{(32-VAL_W){1'b0}}, s_reg.val_even_buf};
        pair_ctl_pkg::VAL_ODD_OFS: s_next.dat =
          {{(32-VAL_W){1'b0}}, s_reg.val_odd_buf};
        pair_ctl_pkg::CAPT_EVEN_OFS: s_next.dat =
          {{(32-VAL_W){1'b0}}, s_reg.capt_even};
        pair_ctl_pkg::CAPT_ODD_OFS: s_next.dat =
          {{(32-VAL_W){1'b0}}, s_reg.capt_odd};
        pair_ctl_pkg::STATUS_OFS: s_next.dat = status_word;
        default: s_next.dat = 32'h00000000;
      endcase
    end

    // fault forces both outputs inactive
    s_next.ch0 = dt.out[0] & ~fault_active;
    s_next.ch1 = dt.out[1] & ~fault_active;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.func <= pair_ctl_pkg::FUNC_RESET;
      s_reg.state <= pair_ctl_pkg::CAP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : channel_pair_combine_control
`default_nettype wire

// >>> design/pair_ctl_pkg.sv
/*
  constants and types shared by the channel pair control block: register
  offsets, field positions, reset values and capture state codes.
  assumes a 32-bit classic wishbone bus with byte addresses.
*/
package pair_ctl_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int DT_W = 6;

  // register byte offsets
  localparam logic [7:0] FUNC_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] VAL_EVEN_OFS = 8'h08;
  localparam logic [7:0] VAL_ODD_OFS = 8'h0c;
  localparam logic [7:0] CAPT_EVEN_OFS = 8'h10;
  localparam logic [7:0] CAPT_ODD_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;

  // channel_pair_function_select field positions
  localparam int JOIN_BIT = 0;
  localparam int INVERT_BIT = 1;
  localparam int DUAL_EDGE_BIT = 2;
  localparam int ARM_BIT = 3;
  localparam int DEADTIME_BIT = 4;
  localparam int SYNC_BIT = 5;
  localparam int FAULT_BIT = 6;
  // guarded fields: fault, deadtime, dual edge, invert, join
  localparam logic [7:0] FUNC_GUARDED = 8'h57;
  // free fields: value sync and capture arm; bit 7 in neither
  localparam logic [7:0] FUNC_FREE = 8'h28;
  localparam logic [7:0] FUNC_RESET = 8'h00;

  // configuration register field positions
  localparam int CFG_GUARD_OFF_BIT = 0;
  localparam int CFG_EXT_ON_BIT = 1;
  localparam int CFG_MODE_A_BIT = 2;
  localparam int CFG_EDGE_EVEN_LSB = 3;
  localparam int CFG_EDGE_ODD_LSB = 5;
  localparam int CFG_DT_LSB = 8;

  // status register field positions
  localparam int ST_DONE_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_STATE_LSB = 2;
  localparam int ST_FAULT_BIT = 5;

  // edge select codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // dual edge capture sequencer states, one-hot
  typedef enum logic [2:0] {
    CAP_IDLE = 3'h1,
    CAP_WAIT_EVEN = 3'h2,
    CAP_WAIT_ODD = 3'h4
  } cap_state_t;
endpackage : pair_ctl_pkg

// >>> design/deadtime_if.sv
/*
  carrier between the pair control and its deadtime inserter.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface deadtime_if;
  logic en; // insertion on
  logic [pair_ctl_pkg::DT_W-1:0] count; // delay in clock cycles
  logic [1:0] want; // requested levels, bit 0 even, bit 1 odd
  logic [1:0] out; // levels after insertion
  modport src (output en, output count, output want, input out);
  modport ins (input en, input count, input want, output out);
endinterface : deadtime_if
`default_nettype wire

// >>> design/deadtime_insert.sv
/*
  deadtime inserter for one channel pair: rising edges are held back by a
  programmable number of clock cycles, falling edges pass at once.
  assumes synchronous inputs on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module deadtime_insert (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pair side
  deadtime_if.ins dt
);
  typedef struct packed {
    logic [1:0][pair_ctl_pkg::DT_W-1:0] cnt; // cycles seen high
    logic [1:0] out; // delayed levels
  } dt_state_t;

  dt_state_t dt_reg;
  dt_state_t dt_next;

  assign dt.out = dt_reg.out;

  // per channel delay counter
  always_comb begin
    dt_next = dt_reg;
    for (int i = 0; i < 2; i++) begin
      if (!dt.want[i]) begin
        // falling edge passes with no delay
        dt_next.cnt[i] = '0;
        dt_next.out[i] = 1'b0;
      end else if (!dt.en || dt_reg.cnt[i] >= dt.count) begin
        // delay spent, or insertion off
        dt_next.out[i] = 1'b1;
      end else begin
        // still inside the dead band
        dt_next.cnt[i] = dt_reg.cnt[i] + 1'b1;
        dt_next.out[i] = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dt_reg <= '0;
    end else begin
      dt_reg <= dt_next;
    end
  end
endmodule : deadtime_insert
`default_nettype wire

// >>> verification/pair_ctl_properties.sv
/*
  port checker for the channel pair control, bound to its top module.
  assumes the bench writes whole words (sel all ones) on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module pair_ctl_properties #(
  parameter int VAL_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // timer side and pins
  input wire logic pwm_even_i,
  input wire logic pwm_odd_i,
  input wire logic [VAL_W-1:0] counter_i,
  input wire logic value_sync_i,
  input wire logic cap_even_pin_i,
  input wire logic cap_odd_pin_i,
  input wire logic fault_pin_i,
  // pair outputs
  input wire logic pwm_ch0_o,
  input wire logic pwm_ch1_o,
  input wire logic [VAL_W-1:0] chan_value_even_o,
  input wire logic [VAL_W-1:0] chan_value_odd_o,
  input wire logic dual_edge_active_o,
  input wire logic pair_fault_ctl_on_o
);
  logic [7:0] func_sh; // expected function bits
  logic guard_sh; // guard off copy
  logic ext_sh; // extended features copy
  logic [5:0] dt_sh; // expected deadtime count
  logic [3:0] quiet; // cycles since last function or config write
  logic wr; // write accepted this edge
  logic [7:0] mask; // bits a function write may change
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign mask = pair_ctl_pkg::FUNC_FREE |
                (guard_sh ? pair_ctl_pkg::FUNC_GUARDED : 8'h00);

  // shadow of the writable fields, guard taken before the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {func_sh, guard_sh, ext_sh, dt_sh, quiet} <= '0;
    end else if (wr && wb_adr_i == pair_ctl_pkg::FUNC_OFS) begin
      func_sh <= (func_sh & ~mask) | (wb_dat_i[7:0] & mask);
      quiet <= 4'h0;
    end else if (wr && wb_adr_i == pair_ctl_pkg::CFG_OFS) begin
      guard_sh <= wb_dat_i[0];
      ext_sh <= wb_dat_i[1];
      if (guard_sh) dt_sh <= wb_dat_i[13:8];
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_reserved;
    wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i == pair_ctl_pkg::FUNC_OFS
      |-> wb_dat_o[31:7] == 25'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved function bits read nonzero");
  property p_readback;
    wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i == pair_ctl_pkg::FUNC_OFS
      && quiet >= 4'h2 |-> (wb_dat_o[7:0] & 8'h77) == (func_sh & 8'h77);
  endproperty
  a_readback: assert property (p_readback)
    else $error("function bits differ from guarded writes");
  property p_fault_bit;
    quiet >= 4'h2 |-> pair_fault_ctl_on_o == func_sh[6];
  endproperty
  a_fault_bit: assert property (p_fault_bit)
    else $error("fault control output differs from its bit");
  property p_fault_out;
    (fault_pin_i && pair_fault_ctl_on_o && func_sh[6])[*5]
      |-> !pwm_ch0_o && !pwm_ch1_o;
  endproperty
  a_fault_out: assert property (p_fault_out)
    else $error("fault did not force outputs low");
  property p_dual;
    quiet >= 4'h3 |-> dual_edge_active_o == (func_sh[2] && ext_sh);
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual edge active wrong");
  property p_comb;
    quiet >= 4'h3 && (func_sh & 8'h55) == 8'h01 |->
      pwm_ch0_o == $past(pwm_even_i, 2) &&
      pwm_ch1_o == ($past(pwm_even_i, 2) ^ func_sh[1]);
  endproperty
  a_comb: assert property (p_comb)
    else $error("combined outputs wrong");
  property p_indep;
    quiet >= 4'h3 && (func_sh & 8'h55) == 8'h00 |->
      pwm_ch0_o == $past(pwm_even_i, 2) && pwm_ch1_o == $past(pwm_odd_i, 2);
  endproperty
  a_indep: assert property (p_indep)
    else $error("independent outputs wrong");
  property p_deadtime;
    quiet >= 4'h3 && (func_sh & 8'h54) == 8'h10 && dt_sh != 6'h0 &&
      $rose(pwm_even_i) |-> ##2 !pwm_ch0_o;
  endproperty
  a_deadtime: assert property (p_deadtime)
    else $error("rising edge not delayed by deadtime");
  property p_sync;
    quiet >= 4'h3 && func_sh[5] && !$past(value_sync_i) &&
      !$past(value_sync_i, 2) |-> $stable(chan_value_even_o);
  endproperty
  a_sync: assert property (p_sync)
    else $error("value changed without sync pulse");

  c_invert: cover property (func_sh[1:0] == 2'h3 && pwm_ch0_o != pwm_ch1_o);
  c_fault: cover property (fault_pin_i && pair_fault_ctl_on_o && !pwm_ch0_o);
  c_dual: cover property (dual_edge_active_o);
endmodule : pair_ctl_properties

bind channel_pair_combine_control pair_ctl_properties #(.VAL_W(VAL_W))
  u_pair_ctl_properties (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pwm_even_i(pwm_even_i), .pwm_odd_i(pwm_odd_i),
  .counter_i(counter_i), .value_sync_i(value_sync_i),
  .cap_even_pin_i(cap_even_pin_i), .cap_odd_pin_i(cap_odd_pin_i),
  .fault_pin_i(fault_pin_i), .pwm_ch0_o(pwm_ch0_o), .pwm_ch1_o(pwm_ch1_o),
  .chan_value_even_o(chan_value_even_o), .chan_value_odd_o(chan_value_odd_o),
  .dual_edge_active_o(dual_edge_active_o),
  .pair_fault_ctl_on_o(pair_fault_ctl_on_o));
`default_nettype wire

// >>> verification/channel_pair_combine_control_bench.sv
/*
  self-checking bench for the channel pair control.
  assumes the checker is bound in; one clock at 100 mhz.
*/
`timescale 1ns/1ps
`default_nettype none
module channel_pair_combine_control_bench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic pwm_even_i, pwm_odd_i, value_sync_i, pwm_ch0_o, pwm_ch1_o;
  logic cap_even_pin_i, cap_odd_pin_i, fault_pin_i;
  logic [15:0] counter_i, chan_value_even_o, chan_value_odd_o;
  logic dual_edge_active_o, pair_fault_ctl_on_o;
  int fail_count, n_checks;

  channel_pair_combine_control #(.VAL_W(16)) u_channel_pair_combine_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pwm_even_i(pwm_even_i), .pwm_odd_i(pwm_odd_i), .counter_i(counter_i),
    .value_sync_i(value_sync_i), .cap_even_pin_i(cap_even_pin_i),
    .cap_odd_pin_i(cap_odd_pin_i), .fault_pin_i(fault_pin_i),
    .pwm_ch0_o(pwm_ch0_o), .pwm_ch1_o(pwm_ch1_o),
    .chan_value_even_o(chan_value_even_o),
    .chan_value_odd_o(chan_value_odd_o),
    .dual_edge_active_o(dual_edge_active_o),
    .pair_fault_ctl_on_o(pair_fault_ctl_on_o));

  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // single exit of the run
  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // wait edges, then let them settle
  task look(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : look

  // classic cycle: hold until ack is sampled, then release
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      look(1);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk

  // reset values and an unmapped address
  task t_reset;
    rchk(pair_ctl_pkg::FUNC_OFS, 32'h0);
    rchk(pair_ctl_pkg::STATUS_OFS, 32'h4);
    wr(8'h40, 32'hff);
    rchk(8'h40, 32'h0);
  endtask : t_reset

  // guarded and free fields, reserved top bit
  task t_guard;
    wr(pair_ctl_pkg::FUNC_OFS, 32'hff);
    rchk(pair_ctl_pkg::FUNC_OFS, 32'h28);
    wr(pair_ctl_pkg::CFG_OFS, 32'h1);
    wr(pair_ctl_pkg::FUNC_OFS, 32'hff);
    rchk(pair_ctl_pkg::FUNC_OFS, 32'h7f);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h0);
    wr(pair_ctl_pkg::CFG_OFS, 32'h0);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h57);
    rchk(pair_ctl_pkg::FUNC_OFS, 32'h0);
    wr(pair_ctl_pkg::CFG_OFS, 32'h1);
  endtask : t_guard

  // independent, combined equal, combined inverted
  task t_pwm;
    int m, v;
    for (m = 0; m < 3; m++) begin
      wr(pair_ctl_pkg::FUNC_OFS, (m == 0) ? 32'h0 : (m == 1) ? 32'h1 : 32'h3);
      for (v = 0; v < 2; v++) begin
        @(posedge clk_i);
        pwm_even_i <= v[0];
        pwm_odd_i <= !v[0];
        look(3);
        check(pwm_ch0_o, v[0]);
        check(pwm_ch1_o, (m == 0) ? !v[0] : v[0] ^ (m == 2));
      end
    end
  endtask : t_pwm

  // fault forces low only with its bit set
  task t_fault;
    wr(pair_ctl_pkg::FUNC_OFS, 32'h40);
    look(2);
    check(pair_fault_ctl_on_o, 1'b1);
    @(posedge clk_i);
    pwm_even_i <= 1'b1;
    pwm_odd_i <= 1'b1;
    fault_pin_i <= 1'b1;
    look(6);
    check({pwm_ch0_o, pwm_ch1_o}, 2'b00);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h0);
    look(4);
    check(pair_fault_ctl_on_o, 1'b0);
    check({pwm_ch0_o, pwm_ch1_o}, 2'b11);
    @(posedge clk_i);
    fault_pin_i <= 1'b0;
    pwm_even_i <= 1'b0;
    pwm_odd_i <= 1'b0;
  endtask : t_fault

  // rising edge held back three cycles, falling edge at once
  task t_deadtime;
    wr(pair_ctl_pkg::CFG_OFS, 32'h301);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h10);
    @(posedge clk_i);
    pwm_even_i <= 1'b1;
    look(3);
    check(pwm_ch0_o, 1'b0);
    look(6);
    check(pwm_ch0_o, 1'b1);
    @(posedge clk_i);
    pwm_even_i <= 1'b0;
    look(3);
    check(pwm_ch0_o, 1'b0);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h0);
    @(posedge clk_i);
    pwm_even_i <= 1'b1;
    look(3);
    check(pwm_ch0_o, 1'b1);
    @(posedge clk_i);
    pwm_even_i <= 1'b0;
  endtask : t_deadtime

  // value update waits for sync only while sync is on
  task t_sync;
    wr(pair_ctl_pkg::FUNC_OFS, 32'h20);
    wr(pair_ctl_pkg::VAL_EVEN_OFS, 32'h1234);
    look(3);
    check(chan_value_even_o, 16'h0);
    @(posedge clk_i);
    value_sync_i <= 1'b1;
    @(posedge clk_i);
    value_sync_i <= 1'b0;
    look(2);
    check(chan_value_even_o, 16'h1234);
    rchk(pair_ctl_pkg::VAL_EVEN_OFS, 32'h1234);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h0);
    wr(pair_ctl_pkg::VAL_ODD_OFS, 32'h5678);
    look(2);
    check(chan_value_odd_o, 16'h5678);
  endtask : t_sync

  // one-shot dual edge capture: even rise, odd fall
  task t_capture;
    wr(pair_ctl_pkg::CFG_OFS, 32'h49);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h0c);
    look(3);
    check(dual_edge_active_o, 1'b0);
    wr(pair_ctl_pkg::CFG_OFS, 32'h4b);
    look(3);
    check(dual_edge_active_o, 1'b1);
    @(posedge clk_i);
    counter_i <= 16'h0011;
    cap_even_pin_i <= 1'b1;
    look(8);
    @(posedge clk_i);
    counter_i <= 16'h0022;
    cap_odd_pin_i <= 1'b0;
    look(8);
    rchk(pair_ctl_pkg::CAPT_EVEN_OFS, 32'h11);
    rchk(pair_ctl_pkg::CAPT_ODD_OFS, 32'h22);
    rchk(pair_ctl_pkg::FUNC_OFS, 32'h04);
    wr(pair_ctl_pkg::FUNC_OFS, 32'h0);
    look(3);
    check(dual_edge_active_o, 1'b0);
  endtask : t_capture

  // main sequence
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, pwm_even_i, pwm_odd_i} = '0;
    {value_sync_i, cap_even_pin_i, fault_pin_i} = '0;
    cap_odd_pin_i = 1'b1;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    counter_i = 16'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_guard();
    t_pwm();
    t_fault();
    t_deadtime();
    t_sync();
    t_capture();
    finish_test();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
endmodule : channel_pair_combine_control_bench
`default_nettype wire
